// ===== logic/trig_pkg.sv
// Shared constants for the trigger data delay and readout block
package trig_pkg;
  localparam int LANES         = 4;
  localparam int LANE_W        = 16;
  localparam int OUT_LANES     = 2;
  localparam int RAW_W         = LANES * LANE_W;
  localparam int RES_W         = OUT_LANES * LANE_W;
  localparam int MAX_DELAY     = 10;
  localparam int DLY_W         = 4;
  localparam int CNT_W         = 5;
  localparam int ADDR_W        = 12;
  localparam int MEM_DEPTH     = 4096;
  localparam int MASK_W        = 2;
  localparam int MASK_RAW_BIT  = 0;
  localparam int MASK_PROC_BIT = 1;
  localparam int FIFO_DEPTH    = 8;
  localparam int RO_W          = RES_W + 1;
  localparam logic [DLY_W-1:0]  MAX_DELAY_V   = 4'hA;
  localparam logic [CNT_W-1:0]  LANE_BITS     = 5'h10;
  localparam logic [CNT_W-1:0]  LAST_BIT      = 5'h0F;
  localparam logic [CNT_W-1:0]  CNT_RST       = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST      = 12'h000;
  localparam logic [RES_W-1:0]  RES_RST       = 32'h0000_0000;
  localparam logic [LANE_W-1:0] LANE_MAX      = 16'hFFFF;
  typedef enum logic [2:0] {RO_IDLE, RO_FETCH, RO_RAW_HI, RO_RAW_LO, RO_PROC} ro_state_e;
endpackage

// ===== logic/sync_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sync_fifo #(
  parameter int W     = 33,
  parameter int DEPTH = 8
) (
  input  wire logic         clk_sys_i,
  input  wire logic         sys_rst_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [0:DEPTH-1];
  logic [AW:0]  wr_ptr_q;
  logic [AW:0]  rd_ptr_q;
  logic         full;
  logic         empty;

  assign empty       = (wr_ptr_q == rd_ptr_q);
  assign full        = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem_q[rd_ptr_q[AW-1:0]];

  always_ff @(posedge clk_sys_i) begin
    if (in_valid_i && !full) begin
      mem_q[wr_ptr_q[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (in_valid_i && !full) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (out_ready_i && !empty) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end
endmodule

// ===== logic/trigger_processing_board.sv
// Data path of the trigger processing board: deserialize, delay, analyse, store, read out
`timescale 1ns/1ps
module trigger_processing_board
  import trig_pkg::*;
(
  input  wire logic                  clk_sys_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  tick_i,
  input  wire logic                  run_i,
  input  wire logic                  latch_addr_i,
  input  wire logic                  play_mode_i,
  input  wire logic [ADDR_W-1:0]     start_addr_i,
  input  wire logic [DLY_W-1:0]      in_delay_i,
  input  wire logic [DLY_W-1:0]      out_delay_i,
  input  wire logic [LANES-1:0]      chan_en_i,
  input  wire logic [LANES-1:0]      ser_in_i,
  input  wire logic                  ser_in_valid_i,
  input  wire logic                  ser_in_frame_i,
  output logic      [OUT_LANES-1:0]  ser_out_o,
  output logic                       ser_out_valid_o,
  output logic                       ser_out_frame_o,
  output logic      [RES_W-1:0]      par_out_o,
  input  wire logic                  rd_cmd_i,
  output logic                       rd_cmd_ready_o,
  input  wire logic [ADDR_W-1:0]     rd_addr_i,
  input  wire logic [MASK_W-1:0]     rd_mask_i,
  output logic      [RES_W-1:0]      ro_data_o,
  output logic                       ro_last_o,
  output logic                       ro_valid_o,
  input  wire logic                  ro_ready_i,
  output logic      [ADDR_W-1:0]     latched_addr_o,
  output logic      [ADDR_W-1:0]     wr_addr_o
);

  function automatic logic [DLY_W-1:0] clamp_delay(input logic [DLY_W-1:0] d);
    clamp_delay = (d > MAX_DELAY_V) ? MAX_DELAY_V : d;
  endfunction

  function automatic logic [LANE_W-1:0] sat_add(input logic [LANE_W-1:0] a,
                                                input logic [LANE_W-1:0] b);
    logic [LANE_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = s[LANE_W] ? LANE_MAX : s[LANE_W-1:0];
  endfunction

  // Deserializer
  logic [LANES-1:0][LANE_W-1:0] des_sh_q;
  logic [LANES-1:0][LANE_W-1:0] des_word_q;
  logic [CNT_W-1:0]             des_cnt_q;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      des_sh_q   <= '0;
      des_word_q <= '0;
      des_cnt_q  <= CNT_RST;
    end else if (ser_in_valid_i) begin
      for (int l = 0; l < LANES; l++) begin
        des_sh_q[l] <= {des_sh_q[l][LANE_W-2:0], ser_in_i[l]};
      end
      if (ser_in_frame_i) begin
        des_cnt_q <= 5'h01;
      end else if (des_cnt_q == LAST_BIT) begin
        des_cnt_q <= CNT_RST;
        for (int l = 0; l < LANES; l++) begin
          des_word_q[l] <= {des_sh_q[l][LANE_W-2:0], ser_in_i[l]};
        end
      end else if (des_cnt_q != CNT_RST) begin
        des_cnt_q <= des_cnt_q + 5'h01;
      end
    end
  end

  // Run control and address counter
  logic [RAW_W-1:0] raw_mem  [0:MEM_DEPTH-1];
  logic [RES_W-1:0] proc_mem [0:MEM_DEPTH-1];
  logic             run_q;
  logic             play_q;
  logic [ADDR_W-1:0] addr_q;
  logic [RAW_W-1:0]  play_word_q;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      run_q  <= 1'b0;
      play_q <= 1'b0;
      addr_q <= ADDR_RST;
    end else begin
      run_q <= run_i;
      if (run_i && !run_q) begin
        addr_q <= start_addr_i;
        play_q <= play_mode_i;
      end else if (tick_i && run_q) begin
        addr_q <= addr_q + 12'h001;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      latched_addr_o <= ADDR_RST;
    end else if (latch_addr_i) begin
      latched_addr_o <= addr_q;
    end
  end

  assign wr_addr_o = addr_q;

  always_ff @(posedge clk_sys_i) begin
    play_word_q <= raw_mem[addr_q];
  end

  // Input delay line, analysis, output delay line
  logic [RAW_W-1:0] src_word;
  logic [RAW_W-1:0] in_dly_q  [0:MAX_DELAY];
  logic [RES_W-1:0] out_dly_q [0:MAX_DELAY];
  logic [RAW_W-1:0] din;
  logic [RES_W-1:0] result_q;
  logic [RES_W-1:0] result_d;
  logic [RES_W-1:0] dout;
  logic [LANES-1:0][LANE_W-1:0] lane_m;

  assign src_word = (run_q && play_q) ? play_word_q : des_word_q;
  assign din      = in_dly_q[clamp_delay(in_delay_i)];
  assign dout     = out_dly_q[clamp_delay(out_delay_i)];

  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      lane_m[l] = chan_en_i[l] ? din[l*LANE_W +: LANE_W] : '0;
    end
    result_d = {sat_add(lane_m[3], lane_m[2]), sat_add(lane_m[1], lane_m[0])};
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i <= MAX_DELAY; i++) begin
        in_dly_q[i]  <= '0;
        out_dly_q[i] <= RES_RST;
      end
      result_q  <= RES_RST;
      par_out_o <= RES_RST;
    end else if (tick_i) begin
      in_dly_q[0]  <= src_word;
      out_dly_q[0] <= result_q;
      for (int i = 1; i <= MAX_DELAY; i++) begin
        in_dly_q[i]  <= in_dly_q[i-1];
        out_dly_q[i] <= out_dly_q[i-1];
      end
      result_q  <= result_d;
      par_out_o <= dout;
    end
  end

  // Circular buffer write of raw and processed sets
  always_ff @(posedge clk_sys_i) begin
    if (tick_i && run_q && !play_q) begin
      raw_mem[addr_q]  <= din;
      proc_mem[addr_q] <= result_q;
    end
  end

  // Serializer, same lane format as input
  logic [OUT_LANES-1:0][LANE_W-1:0] ser_sh_q;
  logic [CNT_W-1:0]                 ser_cnt_q;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ser_sh_q        <= '0;
      ser_cnt_q       <= CNT_RST;
      ser_out_o       <= '0;
      ser_out_valid_o <= 1'b0;
      ser_out_frame_o <= 1'b0;
    end else if (tick_i) begin
      ser_sh_q        <= dout;
      ser_cnt_q       <= LANE_BITS;
      ser_out_valid_o <= 1'b0;
      ser_out_frame_o <= 1'b0;
    end else if (ser_cnt_q != CNT_RST) begin
      for (int l = 0; l < OUT_LANES; l++) begin
        ser_out_o[l]   <= ser_sh_q[l][LANE_W-1];
        ser_sh_q[l]    <= {ser_sh_q[l][LANE_W-2:0], 1'b0};
      end
      ser_out_valid_o <= 1'b1;
      ser_out_frame_o <= (ser_cnt_q == LANE_BITS);
      ser_cnt_q       <= ser_cnt_q - 5'h01;
    end else begin
      ser_out_valid_o <= 1'b0;
      ser_out_frame_o <= 1'b0;
    end
  end

  // Readout engine
  ro_state_e         ro_state_q;
  logic [ADDR_W-1:0] ro_addr_q;
  logic [MASK_W-1:0] ro_mask_q;
  logic [RAW_W-1:0]  ro_raw_q;
  logic [RES_W-1:0]  ro_proc_q;
  logic              f_in_valid;
  logic              f_in_ready;
  logic [RO_W-1:0]   f_in_data;
  logic [RO_W-1:0]   f_out_data;

  assign rd_cmd_ready_o = (ro_state_q == RO_IDLE);

  always_comb begin
    f_in_valid = 1'b0;
    f_in_data  = '0;
    case (ro_state_q)
      RO_RAW_HI: begin
        f_in_valid = 1'b1;
        f_in_data  = {1'b0, ro_raw_q[RAW_W-1:RES_W]};
      end
      RO_RAW_LO: begin
        f_in_valid = 1'b1;
        f_in_data  = {!ro_mask_q[MASK_PROC_BIT], ro_raw_q[RES_W-1:0]};
      end
      RO_PROC: begin
        f_in_valid = 1'b1;
        f_in_data  = {1'b1, ro_proc_q};
      end
      default: begin
        f_in_valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ro_state_q <= RO_IDLE;
      ro_addr_q  <= ADDR_RST;
      ro_mask_q  <= '0;
      ro_raw_q   <= '0;
      ro_proc_q  <= RES_RST;
    end else begin
      case (ro_state_q)
        RO_IDLE: begin
          if (rd_cmd_i && (rd_mask_i != '0)) begin
            ro_addr_q  <= rd_addr_i;
            ro_mask_q  <= rd_mask_i;
            ro_state_q <= RO_FETCH;
          end
        end
        RO_FETCH: begin
          ro_raw_q   <= raw_mem[ro_addr_q];
          ro_proc_q  <= proc_mem[ro_addr_q];
          ro_state_q <= ro_mask_q[MASK_RAW_BIT] ? RO_RAW_HI : RO_PROC;
        end
        RO_RAW_HI: begin
          if (f_in_ready) begin
            ro_state_q <= RO_RAW_LO;
          end
        end
        RO_RAW_LO: begin
          if (f_in_ready) begin
            ro_state_q <= ro_mask_q[MASK_PROC_BIT] ? RO_PROC : RO_IDLE;
          end
        end
        RO_PROC: begin
          if (f_in_ready) begin
            ro_state_q <= RO_IDLE;
          end
        end
        default: begin
          ro_state_q <= RO_IDLE;
        end
      endcase
    end
  end

  sync_fifo #(
    .W     (RO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_ro_fifo (
    .clk_sys_i   (clk_sys_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (f_in_valid),
    .in_ready_o  (f_in_ready),
    .in_data_i   (f_in_data),
    .out_valid_o (ro_valid_o),
    .out_ready_i (ro_ready_i),
    .out_data_o  (f_out_data)
  );

  assign ro_data_o = f_out_data[RES_W-1:0];
  assign ro_last_o = f_out_data[RES_W];

endmodule

// ===== tb/ser_src_model.sv
// Upstream serializer model sending one word per lane, MSB first
`timescale 1ns/1ps
module ser_src_model
  import trig_pkg::*;
(
  input  wire logic             clk_sys_i,
  input  wire logic             go_i,
  input  wire logic [RAW_W-1:0] word_i,
  output logic      [LANES-1:0] ser_o,
  output logic                  valid_o,
  output logic                  frame_o,
  output logic                  busy_o
);
  logic [RAW_W-1:0] sh_q;
  int               n_q = 0;
  initial begin
    ser_o = '0;
    valid_o = 1'b0;
    frame_o = 1'b0;
    busy_o = 1'b0;
  end
  always @(posedge clk_sys_i) begin
    if (go_i && n_q == 0) begin
      sh_q = word_i;
      n_q = LANE_W;
    end
    #0.5;
    if (n_q > 0) begin
      for (int l = 0; l < LANES; l++) ser_o[l] = sh_q[l*LANE_W+n_q-1];
      frame_o = (n_q == LANE_W);
      valid_o = 1'b1;
      n_q--;
    end else begin
      ser_o = ~ser_o;
      valid_o = 1'b0;
      frame_o = 1'b0;
    end
    busy_o = (n_q > 0) || valid_o;
  end
endmodule

// ===== tb/trig_board_chk.sv
// Port assertions for the trigger processing board
`timescale 1ns/1ps
module trig_board_chk
  import trig_pkg::*;
(
  input wire logic              clk_sys_i,
  input wire logic              sys_rst_i,
  input wire logic              tick_i,
  input wire logic              run_i,
  input wire logic              latch_addr_i,
  input wire logic [ADDR_W-1:0] start_addr_i,
  input wire logic              rd_cmd_i,
  input wire logic              rd_cmd_ready_o,
  input wire logic [MASK_W-1:0] rd_mask_i,
  input wire logic              ro_valid_o,
  input wire logic              ro_ready_i,
  input wire logic [RES_W-1:0]  ro_data_o,
  input wire logic              ro_last_o,
  input wire logic              ser_out_valid_o,
  input wire logic              ser_out_frame_o,
  input wire logic [RES_W-1:0]  par_out_o,
  input wire logic [ADDR_W-1:0] latched_addr_o,
  input wire logic [ADDR_W-1:0] wr_addr_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_take;
    rd_cmd_i && rd_cmd_ready_o && rd_mask_i != '0;
  endsequence
  sequence s_rise;
    run_i && !$past(run_i);
  endsequence
  sequence s_no_tick;
    !tick_i [*8];
  endsequence
  a_cmd_busy: assert property (s_take |=> !rd_cmd_ready_o)
    else $error("engine still ready after command");
  a_ro_first: assert property (s_take ##0 !ro_valid_o |-> ##3 ro_valid_o)
    else $error("first readout word late");
  a_ro_hold: assert property (ro_valid_o && !ro_ready_i |=>
    ro_valid_o && $stable(ro_data_o) && $stable(ro_last_o))
    else $error("readout word dropped while stalled");
  a_addr_load: assert property (s_rise |=> wr_addr_o == $past(start_addr_i))
    else $error("start address not loaded");
  a_addr_step: assert property (tick_i && run_i && $past(run_i) |=>
    wr_addr_o == $past(wr_addr_o) + 12'h001)
    else $error("address did not advance by one");
  a_addr_hold: assert property (!tick_i && !(run_i && !$past(run_i)) |=>
    $stable(wr_addr_o))
    else $error("address moved without tick");
  a_latch_copy: assert property (latch_addr_i |=> latched_addr_o == $past(wr_addr_o))
    else $error("latched address wrong");
  a_ser_start: assert property (tick_i ##1 !tick_i |=> ser_out_valid_o && ser_out_frame_o)
    else $error("serial word did not start");
  a_ser_tail: assert property (ser_out_frame_o ##0 s_no_tick |=>
    ser_out_valid_o && !ser_out_frame_o)
    else $error("serial word broken");
  a_par_tick: assert property (!tick_i |=> $stable(par_out_o))
    else $error("result changed between ticks");
endmodule
bind trigger_processing_board trig_board_chk trig_board_chk_i (.*);

// ===== tb/test_trigger_data_delay_readout.sv
// Self-checking bench for the trigger processing board
`timescale 1ns/1ps
module test_trigger_data_delay_readout;
  import trig_pkg::*;
  localparam logic [RAW_W-1:0] W1 = 64'h0004_0003_FFF0_0020;
  localparam logic [RAW_W-1:0] W2 = 64'h1000_2000_0123_0456;
  localparam logic [RAW_W-1:0] W3 = 64'h8000_9000_0011_0022;
  logic clk_sys_i = 0, sys_rst_i = 1, tick_i = 0, run_i = 0, latch_addr_i = 0;
  logic play_mode_i = 0, rd_cmd_i = 0, ro_ready_i = 1, go = 0, busy;
  logic ser_in_valid_i, ser_in_frame_i, ser_out_valid_o, ser_out_frame_o;
  logic rd_cmd_ready_o, ro_last_o, ro_valid_o;
  logic [ADDR_W-1:0]    start_addr_i = '0, rd_addr_i = '0, latched_addr_o, wr_addr_o;
  logic [DLY_W-1:0]     in_delay_i = '0, out_delay_i = '0;
  logic [LANES-1:0]     chan_en_i = '1, ser_in_i;
  logic [MASK_W-1:0]    rd_mask_i = '0;
  logic [OUT_LANES-1:0] ser_out_o;
  logic [RES_W-1:0]     par_out_o, ro_data_o;
  logic [RAW_W-1:0]     word = '0;
  int                   fail_count = 0, comparisons = 0, cyc = 0;
  trigger_processing_board trigger_processing_board_i (.*);
  ser_src_model ser_src_model_i (.clk_sys_i, .go_i(go), .word_i(word), .ser_o(ser_in_i),
    .valid_o(ser_in_valid_i), .frame_o(ser_in_frame_i), .busy_o(busy));
  initial forever #2.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic summarize();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [RES_W-1:0] got, exp, input string m);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic tk();
    tick_i = 1;
    step(1);
    tick_i = 0;
    step(3);
  endtask
  function automatic logic [LANE_W:0] ln(input logic [RAW_W-1:0] w, input int l);
    return chan_en_i[l] ? {1'b0, w[l*LANE_W+:LANE_W]} : '0;
  endfunction
  function automatic logic [RES_W-1:0] res(input logic [RAW_W-1:0] w);
    logic [LANE_W:0] a, b;
    a = ln(w, 0) + ln(w, 1);
    b = ln(w, 2) + ln(w, 3);
    return {b[LANE_W] ? LANE_MAX : b[LANE_W-1:0], a[LANE_W] ? LANE_MAX : a[LANE_W-1:0]};
  endfunction
  task automatic send(input logic [RAW_W-1:0] w);
    word = w;
    go = 1;
    step(1);
    go = 0;
    repeat (40) if (busy !== 1'b0) step(1);
    step(1);
  endtask
  task automatic sc_delay(input logic [DLY_W-1:0] di, dq, input logic [RAW_W-1:0] w,
                          input int exp_n);
    int n;
    in_delay_i = di;
    out_delay_i = dq;
    send(w);
    n = 0;
    while (par_out_o !== res(w) && n < 40) begin
      tk();
      n++;
    end
    chk(RES_W'(n), RES_W'(exp_n), "tick latency");
  endtask
  task automatic sc_serial();
    logic [RES_W-1:0] got;
    tick_i = 1;
    step(1);
    tick_i = 0;
    step(1);
    chk(RES_W'({ser_out_valid_o, ser_out_frame_o}), 32'h0000_0003, "serial frame");
    for (int b = LANE_W - 1; b >= 0; b--) begin
      got[b] = ser_out_o[0];
      got[LANE_W+b] = ser_out_o[1];
      step(1);
    end
    chk(got, res(W3), "serial word");
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [MASK_W-1:0] m);
    repeat (50) if (rd_cmd_ready_o !== 1'b1) step(1);
    rd_addr_i = a;
    rd_mask_i = m;
    rd_cmd_i = 1;
    step(1);
    rd_cmd_i = 0;
  endtask
  task automatic pop(input logic [RES_W-1:0] e, input logic l);
    ro_ready_i = 1;
    repeat (50) if (ro_valid_o !== 1'b1) step(1);
    chk(ro_data_o, e, "readout word");
    chk(RES_W'(ro_last_o), RES_W'(l), "last flag");
    step(1);
  endtask
  task automatic sc_record();
    in_delay_i = 0;
    out_delay_i = 0;
    start_addr_i = 12'hFFE;
    repeat (4) tk();
    run_i = 1;
    step(1);
    chk(RES_W'(wr_addr_o), 32'h0000_0FFE, "start address");
    repeat (3) tk();
    chk(RES_W'(wr_addr_o), 32'h0000_0001, "wrapped address");
    latch_addr_i = 1;
    step(1);
    latch_addr_i = 0;
    step(1);
    chk(RES_W'(latched_addr_o), 32'h0000_0001, "latched address");
  endtask
  task automatic sc_masks();
    rd(12'hFFF, 2'b01);
    pop(W3[63:32], 0);
    pop(W3[31:0], 1);
    rd(12'h000, 2'b10);
    pop(res(W3), 1);
    rd(12'hFFE, 2'b00);
    step(6);
    chk(RES_W'({ro_valid_o, rd_cmd_ready_o}), 32'h0000_0001, "empty mask");
  endtask
  task automatic sc_fill();
    ro_ready_i = 0;
    rd(12'hFFF, 2'b11);
    rd(12'h000, 2'b11);
    rd(12'hFFE, 2'b11);
    repeat (4) tk();
    chk(RES_W'(rd_cmd_ready_o), '0, "stall on full buffer");
    chk(RES_W'(wr_addr_o), 32'h0000_0005, "writes during readout");
    repeat (3) begin
      pop(W3[63:32], 0);
      pop(W3[31:0], 0);
      pop(res(W3), 1);
    end
    chk(RES_W'({ro_valid_o, rd_cmd_ready_o}), 32'h0000_0001, "drained");
  endtask
  task automatic sc_play();
    run_i = 0;
    step(1);
    send(W1);
    play_mode_i = 1;
    start_addr_i = 12'h000;
    run_i = 1;
    step(2);
    repeat (4) tk();
    chk(par_out_o, res(W3), "playback word");
    chk(RES_W'(wr_addr_o), 32'h0000_0004, "playback address");
  endtask
  initial begin
    step(20);
    sys_rst_i = 0;
    step(1);
    sc_delay(4'h0, 4'h0, W1, 4);
    chan_en_i = 4'b1101;
    sc_delay(4'h3, 4'h1, W2, 8);
    chan_en_i = '1;
    sc_delay(4'hF, 4'hA, W3, 24);
    sc_serial();
    sc_record();
    sc_masks();
    sc_fill();
    sc_play();
    summarize();
  end
endmodule
